//--- inc/usb_ep_fifo_pkg.sv
// Purpose: Constants for the endpoint FIFO status and transmit load block.
// Assumes: APB with 32-bit data; every register takes one aligned word.
// Notes: Bytes sit in the low bits; the upper bits read as zero.
package usb_ep_fifo_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int PTR_W = 3;
   localparam int LVL_W = 4;
   localparam int LEN_W = 4;
   localparam int INT_W = 2;
   // Register byte offsets.
   localparam logic [7:0] RX_FLAGS_OFS = 8'h00;
   localparam logic [7:0] TX_DATA_OFS = 8'h04;
   localparam logic [7:0] TX_LEN_OFS = 8'h08;
   localparam logic [7:0] RX_DATA_OFS = 8'h0C;
   localparam logic [7:0] CTRL_OFS = 8'h10;
   localparam logic [7:0] TX_STAT_OFS = 8'h14;
   localparam logic [7:0] INT_STAT_OFS = 8'h18;
   localparam logic [7:0] INT_MASK_OFS = 8'h1C;
   // Receive flag and transmit status bit positions.
   localparam int VACANT_BIT = 3;
   localparam int FULL_BIT = 2;
   localparam int UNDER_BIT = 1;
   localparam int OVER_BIT = 0;
   // Control register bit positions.
   localparam int RX_CLEAR_BIT = 0;
   localparam int TX_FLUSH_BIT = 1;
   localparam int TX_STALL_BIT = 2;
   localparam int TX_ARMED_BIT = 3;
   // Interrupt bit positions.
   localparam int INT_RX_BIT = 0;
   localparam int INT_TX_ACK_BIT = 1;
   // Reset values.
   localparam logic [LEN_W-1:0] TX_LEN_RST = 4'h0;
   localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;
   typedef enum logic [1:0] {
      REPLY_DATA,
      REPLY_NACK,
      REPLY_STALL
   } in_reply_e;
endpackage

//--- core/byte_fifo.sv
// Purpose: Small byte FIFO with flush, level, empty and full.
// Assumes: Writes when full and reads when empty are ignored here.
// Notes: Read data shows the head byte without a pop.
module byte_fifo (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Control.
   input wire logic flush,
   // Write side.
   input wire logic wrEn,
   input wire logic [usb_ep_fifo_pkg::BYTE_W-1:0] wrData,
   // Read side.
   input wire logic rdEn,
   output logic [usb_ep_fifo_pkg::BYTE_W-1:0] rdData,
   // State.
   output logic [usb_ep_fifo_pkg::LVL_W-1:0] level,
   output logic empty,
   output logic full
);
   logic [usb_ep_fifo_pkg::BYTE_W-1:0] mem [usb_ep_fifo_pkg::FIFO_DEPTH];
   logic [usb_ep_fifo_pkg::PTR_W-1:0] wrPtr_q;
   logic [usb_ep_fifo_pkg::PTR_W-1:0] rdPtr_q;
   logic [usb_ep_fifo_pkg::LVL_W-1:0] level_q;
   logic doWr;
   logic doRd;

   assign empty = (level_q == '0);
   assign full = (level_q == usb_ep_fifo_pkg::LVL_W'(
      usb_ep_fifo_pkg::FIFO_DEPTH));
   assign level = level_q;
   assign rdData = mem[rdPtr_q];
   assign doWr = wrEn && !full && !flush;
   assign doRd = rdEn && !empty && !flush;

   always_ff @(posedge clock) begin
      if (doWr) begin
         mem[wrPtr_q] <= wrData;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b || flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         level_q <= '0;
      end else begin
         if (doWr) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (doRd) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (doWr && !doRd) begin
            level_q <= level_q + 1'b1;
         end else if (doRd && !doWr) begin
            level_q <= level_q - 1'b1;
         end
      end
   end
endmodule

//--- core/usb_endpoint_fifo_status_and_tx_load.sv
// Purpose: Endpoint 0 receive FIFO flags and endpoint 1 transmit load.
// Assumes: Function logic runs on the same clock; APB is zero-wait
//    plus one registered wait cycle.
// Notes: All outputs are registered.
module usb_endpoint_fifo_status_and_tx_load (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [usb_ep_fifo_pkg::ADDR_W-1:0] paddr,
   input wire logic [usb_ep_fifo_pkg::DATA_W-1:0] pwdata,
   output logic [usb_ep_fifo_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt.
   output logic irq,
   // Receive bytes from function logic.
   input wire logic rxWrValid,
   input wire logic [usb_ep_fifo_pkg::BYTE_W-1:0] rxWrData,
   // IN transactions from function logic.
   input wire logic inToken,
   output logic inReplyValid,
   output logic [1:0] inReply,
   output logic [usb_ep_fifo_pkg::LEN_W-1:0] txPacketLength,
   // Transmit bytes to function logic.
   input wire logic txRdReq,
   output logic txRdValid,
   output logic [usb_ep_fifo_pkg::BYTE_W-1:0] txRdData,
   input wire logic txAck
);
   localparam int BW = usb_ep_fifo_pkg::BYTE_W;
   localparam int DW = usb_ep_fifo_pkg::DATA_W;
   localparam int IW = usb_ep_fifo_pkg::INT_W;

   logic pready_q;
   logic pslverr_q;
   logic [DW-1:0] prdata_q;
   logic accessHit;
   logic wrStb;
   logic rdStb;
   logic mapped;
   logic [DW-1:0] rdValue;

   logic [BW-1:0] rxHead;
   logic rxEmpty;
   logic rxFull;
   logic rxPop;
   logic rxUnder_q;
   logic rxOver_q;
   logic rxUnderEvt;
   logic rxOverEvt;
   logic rxClearPend_q;

   logic [BW-1:0] txHead;
   logic txEmpty;
   logic txFull;
   logic txPush;
   logic txPop;
   logic txUnder_q;
   logic txOver_q;
   logic txUnderEvt;
   logic txOverEvt;
   logic txFlushPend_q;
   logic txArmed_q;
   logic txStall_q;
   logic [usb_ep_fifo_pkg::LEN_W-1:0] txLen_q;

   logic [IW-1:0] intStat_q;
   logic [IW-1:0] intMask_q;
   logic [IW-1:0] intSet;
   logic [IW-1:0] intClr;
   logic irq_q;

   logic inReplyValid_q;
   usb_ep_fifo_pkg::in_reply_e inReply_q;
   logic txRdValid_q;
   logic [BW-1:0] txRdData_q;

   // The answer comes one cycle into the access phase.
   assign accessHit = psel && penable && !pready_q;
   assign wrStb = accessHit && pwrite;
   assign rdStb = accessHit && !pwrite;

   always_comb begin
      mapped = 1'b1;
      rdValue = '0;
      if (paddr == usb_ep_fifo_pkg::RX_FLAGS_OFS) begin
         rdValue[usb_ep_fifo_pkg::VACANT_BIT] = rxEmpty;
         rdValue[usb_ep_fifo_pkg::FULL_BIT] = rxFull;
         rdValue[usb_ep_fifo_pkg::UNDER_BIT] = rxUnder_q;
         rdValue[usb_ep_fifo_pkg::OVER_BIT] = rxOver_q;
      end else if (paddr == usb_ep_fifo_pkg::TX_DATA_OFS) begin
         rdValue = '0;
      end else if (paddr == usb_ep_fifo_pkg::TX_LEN_OFS) begin
         rdValue[usb_ep_fifo_pkg::LEN_W-1:0] = txLen_q;
      end else if (paddr == usb_ep_fifo_pkg::RX_DATA_OFS) begin
         rdValue[BW-1:0] = rxEmpty ? '0 : rxHead;
      end else if (paddr == usb_ep_fifo_pkg::CTRL_OFS) begin
         rdValue[usb_ep_fifo_pkg::RX_CLEAR_BIT] = rxClearPend_q;
         rdValue[usb_ep_fifo_pkg::TX_FLUSH_BIT] = txFlushPend_q;
         rdValue[usb_ep_fifo_pkg::TX_STALL_BIT] = txStall_q;
         rdValue[usb_ep_fifo_pkg::TX_ARMED_BIT] = txArmed_q;
      end else if (paddr == usb_ep_fifo_pkg::TX_STAT_OFS) begin
         rdValue[usb_ep_fifo_pkg::VACANT_BIT] = txEmpty;
         rdValue[usb_ep_fifo_pkg::FULL_BIT] = txFull;
         rdValue[usb_ep_fifo_pkg::UNDER_BIT] = txUnder_q;
         rdValue[usb_ep_fifo_pkg::OVER_BIT] = txOver_q;
      end else if (paddr == usb_ep_fifo_pkg::INT_STAT_OFS) begin
         rdValue[IW-1:0] = intStat_q;
      end else if (paddr == usb_ep_fifo_pkg::INT_MASK_OFS) begin
         rdValue[IW-1:0] = intMask_q;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= accessHit;
         pslverr_q <= accessHit && !mapped;
         if (rdStb) begin
            prdata_q <= rdValue;
         end
      end
   end

   // Receive path.
   // Reads pop in order.
   assign rxPop = rdStb && (paddr == usb_ep_fifo_pkg::RX_DATA_OFS)
      && !rxEmpty;
   assign rxUnderEvt = rdStb && (paddr == usb_ep_fifo_pkg::RX_DATA_OFS)
      && rxEmpty;
   assign rxOverEvt = rxWrValid && rxFull && !rxClearPend_q;

   byte_fifo rxFifo (
      .clock(clock),
      .rst_b(rst_b),
      .flush(rxClearPend_q),
      .wrEn(rxWrValid),
      .wrData(rxWrData),
      .rdEn(rxPop),
      .rdData(rxHead),
      .level(),
      .empty(rxEmpty),
      .full(rxFull)
   );

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rxClearPend_q <= 1'b0;
      end else if (rxClearPend_q) begin
         rxClearPend_q <= 1'b0;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::CTRL_OFS) begin
         rxClearPend_q <= pwdata[usb_ep_fifo_pkg::RX_CLEAR_BIT];
      end
   end

   // Clear drops errors; a new underflow wins, and overflow is not flagged during a clear.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rxUnder_q <= 1'b0;
         rxOver_q <= 1'b0;
      end else begin
         if (rxUnderEvt) begin
            rxUnder_q <= 1'b1;
         end else if (rxClearPend_q) begin
            rxUnder_q <= 1'b0;
         end
         if (rxOverEvt) begin
            rxOver_q <= 1'b1;
         end else if (rxClearPend_q) begin
            rxOver_q <= 1'b0;
         end
      end
   end

   // Transmit path.
   // Each data write appends a byte unless the FIFO is full or a flush is pending.
   assign txPush = wrStb && (paddr == usb_ep_fifo_pkg::TX_DATA_OFS)
      && !txFull && !txFlushPend_q;
   assign txOverEvt = wrStb && (paddr == usb_ep_fifo_pkg::TX_DATA_OFS)
      && txFull && !txFlushPend_q;
   assign txPop = txRdReq && !txEmpty && !txFlushPend_q;
   assign txUnderEvt = txRdReq && txEmpty && !txFlushPend_q;

   byte_fifo txFifo (
      .clock(clock),
      .rst_b(rst_b),
      .flush(txFlushPend_q),
      .wrEn(txPush),
      .wrData(pwdata[BW-1:0]),
      .rdEn(txPop),
      .rdData(txHead),
      .level(),
      .empty(txEmpty),
      .full(txFull)
   );

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txFlushPend_q <= 1'b0;
      end else if (txFlushPend_q) begin
         txFlushPend_q <= 1'b0;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::CTRL_OFS) begin
         txFlushPend_q <= pwdata[usb_ep_fifo_pkg::TX_FLUSH_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txUnder_q <= 1'b0;
         txOver_q <= 1'b0;
      end else if (txFlushPend_q) begin
         txUnder_q <= 1'b0;
         txOver_q <= 1'b0;
      end else begin
         if (txUnderEvt) begin
            txUnder_q <= 1'b1;
         end
         if (txOverEvt) begin
            txOver_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txLen_q <= usb_ep_fifo_pkg::TX_LEN_RST;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::TX_LEN_OFS) begin
         txLen_q <= pwdata[usb_ep_fifo_pkg::LEN_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txStall_q <= 1'b0;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::CTRL_OFS) begin
         txStall_q <= pwdata[usb_ep_fifo_pkg::TX_STALL_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txArmed_q <= 1'b0;
      end else if (txFlushPend_q) begin
         txArmed_q <= 1'b0;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::TX_LEN_OFS) begin
         txArmed_q <= 1'b1;
      end else if (txAck) begin
         txArmed_q <= 1'b0;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::CTRL_OFS) begin
         txArmed_q <= pwdata[usb_ep_fifo_pkg::TX_ARMED_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         inReplyValid_q <= 1'b0;
         inReply_q <= usb_ep_fifo_pkg::REPLY_NACK;
      end else begin
         inReplyValid_q <= inToken;
         if (inToken) begin
            if (txArmed_q) begin
               inReply_q <= usb_ep_fifo_pkg::REPLY_DATA;
            end else if (txStall_q) begin
               inReply_q <= usb_ep_fifo_pkg::REPLY_STALL;
            end else begin
               inReply_q <= usb_ep_fifo_pkg::REPLY_NACK;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         txRdValid_q <= 1'b0;
         txRdData_q <= '0;
      end else begin
         txRdValid_q <= txPop;
         if (txPop) begin
            txRdData_q <= txHead;
         end
      end
   end

   // Interrupts.
   always_comb begin
      intSet = '0;
      intClr = '0;
      intSet[usb_ep_fifo_pkg::INT_RX_BIT] = rxUnderEvt || rxOverEvt;
      intSet[usb_ep_fifo_pkg::INT_TX_ACK_BIT] = txAck;
      if (wrStb && paddr == usb_ep_fifo_pkg::INT_STAT_OFS) begin
         intClr = pwdata[IW-1:0];
      end
      if (rxClearPend_q) begin
         intClr[usb_ep_fifo_pkg::INT_RX_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         intStat_q <= '0;
      end else begin
         intStat_q <= (intStat_q & ~intClr) | intSet;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         intMask_q <= usb_ep_fifo_pkg::INT_MASK_RST;
      end else if (wrStb && paddr == usb_ep_fifo_pkg::INT_MASK_OFS) begin
         intMask_q <= pwdata[IW-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(intStat_q & intMask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign inReplyValid = inReplyValid_q;
   assign inReply = inReply_q;
   assign txPacketLength = txLen_q;
   assign txRdValid = txRdValid_q;
   assign txRdData = txRdData_q;
endmodule

//--- tb/usb_ep_fifo_chk.sv
// Purpose: Port assertions for the endpoint FIFO block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the block.
module usb_ep_fifo_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Function side.
   input wire logic inToken,
   input wire logic inReplyValid,
   input wire logic [1:0] inReply,
   input wire logic txRdReq,
   input wire logic txRdValid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   logic rdDone;
   assign rdDone = pready && !pwrite;
   chk_flags_resv: assert property (
      rdDone && paddr == 8'h00 |-> prdata[31:4] == 28'h000_0000)
      else $error("flag reserved bits set");
   chk_flags_excl: assert property (
      rdDone && paddr == 8'h00 |-> !(prdata[3] && prdata[2]))
      else $error("vacant and full together");
   chk_flags_mapped: assert property (
      pready && paddr == 8'h00 |-> !pslverr)
      else $error("flag register refused");
   chk_len_resv: assert property (
      rdDone && paddr == 8'h08 |-> prdata[31:4] == 28'h000_0000)
      else $error("length upper bits set");
   chk_port_wo: assert property (
      rdDone && paddr == 8'h04 |-> prdata == 32'h0000_0000)
      else $error("data port readable");
   chk_wait_one: assert property (
      psel && penable && !pready |-> ##1 pready ##1 !pready)
      else $error("ready timing wrong");
   chk_in_reply: assert property (
      inToken |=> inReplyValid)
      else $error("IN not answered");
   chk_in_cause: assert property (
      inReplyValid |-> $past(inToken))
      else $error("reply without IN");
   chk_in_code: assert property (
      inReplyValid |-> inReply != 2'b11)
      else $error("reply code unused");
   chk_pop_cause: assert property (
      txRdValid |-> $past(txRdReq))
      else $error("byte without request");
endmodule

bind usb_endpoint_fifo_status_and_tx_load usb_ep_fifo_chk chk (
   .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .inToken, .inReplyValid, .inReply, .txRdReq,
   .txRdValid
);

//--- tb/usb_fn_model.sv
// Purpose: Function control logic on the far side of the block.
// Assumes: Same clock; every request is a one-cycle pulse.
// Notes: Released data lines show the inverse of the last byte.
module usb_fn_model (
   // Clock.
   input wire logic clock,
   // Requests.
   output logic rxWrValid,
   output logic [7:0] rxWrData,
   output logic inToken,
   output logic txRdReq,
   output logic txAck,
   // Answers.
   input wire logic inReplyValid,
   input wire logic [1:0] inReply,
   input wire logic txRdValid,
   input wire logic [7:0] txRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rxWrValid = 1'b0;
      rxWrData = 8'h00;
      inToken = 1'b0;
      txRdReq = 1'b0;
      txAck = 1'b0;
   end
   task automatic push(input logic [7:0] b);
      @(posedge clock);
      rxWrValid <= 1'b1;
      rxWrData <= b;
      @(posedge clock);
      rxWrValid <= 1'b0;
      rxWrData <= ~b;
   endtask
   task automatic in_txn(output logic [2:0] vr);
      @(posedge clock);
      inToken <= 1'b1;
      @(posedge clock);
      inToken <= 1'b0;
      @(posedge clock);
      vr = {inReplyValid, inReply};
   endtask
   task automatic pop(output logic [8:0] vd);
      @(posedge clock);
      txRdReq <= 1'b1;
      @(posedge clock);
      txRdReq <= 1'b0;
      @(posedge clock);
      vd = {txRdValid, txRdData};
   endtask
   task automatic ack();
      @(posedge clock);
      txAck <= 1'b1;
      @(posedge clock);
      txAck <= 1'b0;
   endtask
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the endpoint FIFO block.
// Assumes: APB master holds each request until pready.
// Notes: Far side is played by the function model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq, lastErr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic rxWrValid, inToken, inReplyValid, txRdReq, txRdValid, txAck;
   logic [7:0] rxWrData, txRdData;
   logic [1:0] inReply;
   logic [3:0] txPacketLength;
   logic [2:0] vr;
   logic [8:0] vd;
   int num_errors = 0;
   int tests_run = 0;
   always #4 clock = ~clock;
   usb_endpoint_fifo_status_and_tx_load DUT (
      .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq, .rxWrValid, .rxWrData,
      .inToken, .inReplyValid, .inReply, .txPacketLength,
      .txRdReq, .txRdValid, .txRdData, .txAck
   );
   usb_fn_model fn (
      .clock, .rxWrValid, .rxWrData, .inToken, .txRdReq, .txAck,
      .inReplyValid, .inReply, .txRdValid, .txRdData
   );
   task automatic complete_run();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic fail(input string m);
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
         fail($sformatf("got %h want %h", g, e));
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      rdat = prdata;
      lastErr = pslverr;
      if (pready !== 1'b1) begin
         fail("no pready");
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rdat, e);
   endtask
   task automatic t_rx();
      wr(8'h1C, 32'h0000_0001);
      rd(8'h00, 32'h0000_0008);
      for (int i = 0; i < 8; i++)
         fn.push(8'hA0 + 8'(i));
      rd(8'h00, 32'h0000_0004);
      fn.push(8'h5A);
      rd(8'h00, 32'h0000_0005);
      rd(8'h18, 32'h0000_0001);
      cmp({31'h0, irq}, 32'h0000_0001);
      wr(8'h1C, 32'h0000_0000);
      rd(8'h00, 32'h0000_0005);
      cmp({31'h0, irq}, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
         rd(8'h0C, 32'h0000_00A0 + i);
      rd(8'h00, 32'h0000_0009);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h00, 32'h0000_000B);
      wr(8'h1C, 32'h0000_0001);
      wr(8'h10, 32'h0000_0001);
      rd(8'h00, 32'h0000_0008);
      rd(8'h18, 32'h0000_0000);
      cmp({31'h0, irq}, 32'h0000_0000);
   endtask
   task automatic t_tx();
      for (int i = 0; i < 3; i++)
         wr(8'h04, 32'hFFFF_FF10 + i);
      rd(8'h04, 32'h0000_0000);
      fn.in_txn(vr);
      cmp(32'(vr), 32'h0000_0005);
      wr(8'h10, 32'h0000_0004);
      fn.in_txn(vr);
      cmp(32'(vr), 32'h0000_0006);
      wr(8'h10, 32'h0000_0000);
      wr(8'h08, 32'h0000_0003);
      rd(8'h10, 32'h0000_0008);
      fn.in_txn(vr);
      cmp(32'(vr), 32'h0000_0004);
      for (int i = 0; i < 3; i++) begin
         fn.pop(vd);
         cmp(32'(vd), 32'h0000_0110 + i);
      end
      fn.pop(vd);
      cmp(32'(vd), 32'h0000_0012);
      rd(8'h14, 32'h0000_000A);
      fn.ack();
      rd(8'h10, 32'h0000_0000);
      rd(8'h08, 32'h0000_0003);
      cmp(32'(txPacketLength), 32'h0000_0003);
      rd(8'h18, 32'h0000_0002);
      wr(8'h18, 32'h0000_0003);
      rd(8'h18, 32'h0000_0000);
      wr(8'h04, 32'h0000_0077);
      wr(8'h08, 32'h0000_0001);
      wr(8'h10, 32'h0000_000A);
      rd(8'h10, 32'h0000_0000);
      rd(8'h14, 32'h0000_0008);
      rd(8'h40, 32'h0000_0000);
      cmp(32'(lastErr), 32'h0000_0001);
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h08, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      t_rx();
      t_tx();
      complete_run();
   end
endmodule
